// >>> swc_pkg.sv
package swc_pkg;

    // ====================================================================
    // register map (word index = addr)
    // ====================================================================
    localparam int          ADDR_W          = 6;
    localparam int          GRP_W           = 32;
    localparam logic [5:0]  OFF_FLAG_G0A    = 6'h00;
    localparam logic [5:0]  OFF_FLAG_G0I    = 6'h01;
    localparam logic [5:0]  OFF_FLAG_G1A    = 6'h02;
    localparam logic [5:0]  OFF_FLAG_G1I    = 6'h03;
    localparam logic [5:0]  OFF_MASK_G0A    = 6'h04;
    localparam logic [5:0]  OFF_MASK_G0I    = 6'h05;
    localparam logic [5:0]  OFF_MASK_G1A    = 6'h06;
    localparam logic [5:0]  OFF_MASK_G1I    = 6'h07;
    localparam logic [5:0]  OFF_CLR_G0A     = 6'h08;
    localparam logic [5:0]  OFF_CLR_G0I     = 6'h09;
    localparam logic [5:0]  OFF_CLR_G1A     = 6'h0a;
    localparam logic [5:0]  OFF_CLR_G1I     = 6'h0b;
    localparam logic [5:0]  OFF_MODE        = 6'h0c;
    localparam logic [5:0]  OFF_STATUS      = 6'h0d;
    localparam logic [5:0]  OFF_IRQ_STAT    = 6'h0e;
    localparam logic [5:0]  OFF_IRQ_EN      = 6'h0f;
    localparam logic [5:0]  OFF_IRQ_CLR     = 6'h10;

    // ====================================================================
    // reset values and fields
    // ====================================================================
    localparam logic [31:0] MASK_RST        = 32'hffffffff;
    localparam int          MODE_CMD_LSB    = 0;
    localparam int          MODE_OSC_BIT    = 4;
    localparam int          DEEP_SRC_N      = 3;
    localparam int          IRQ_N           = 2;
    localparam int          IRQ_WAKE        = 0;
    localparam int          IRQ_FLAG        = 1;

    // ====================================================================
    // mode, clock and fetch enumerations
    // ====================================================================
    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_STOP,
        SWC_DEEP,
        SWC_CYC_STOP
    } swc_power_t;

    typedef enum logic [1:0] {
        SWC_CMD_NONE,
        SWC_CMD_STOP,
        SWC_CMD_DEEP,
        SWC_CMD_CYC_STOP
    } swc_cmd_t;

    typedef enum logic [1:0] {
        SWC_FETCH_NEXT,
        SWC_FETCH_FLASH_RST,
        SWC_FETCH_RRAM_RST
    } swc_fetch_t;

    typedef enum logic [1:0] {
        SWC_CLK_KEEP,
        SWC_CLK_IOSC_HI,
        SWC_CLK_IOSC_LO
    } swc_clk_t;

endpackage

// >>> swc_flag_if.sv
`timescale 1ns/1ns
interface swc_flag_if
    import swc_pkg::*;
#(
    parameter int W = GRP_W
);
    logic [W-1:0] src;
    logic [W-1:0] mask;
    logic [W-1:0] clr;
    logic [W-1:0] flags;
    logic         hit;

    modport bank (input src, input mask, input clr, output flags, output hit);
    modport ctrl (output src, output mask, output clr, input flags, input hit);
endinterface

// >>> swc_flag_bank.sv
`timescale 1ns/1ns
module swc_flag_bank
    import swc_pkg::*;
#(
    parameter int W = GRP_W
)
(
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // flag group
    swc_flag_if.bank   fi
);
    logic [W-1:0] flags_q;
    logic [W-1:0] eff;

    // a source counts only where its own mask bit is zero
    assign eff = fi.src & ~fi.mask;

    // event wins over a simultaneous clear; flag records event only
    always_ff @(posedge clk)
    begin
        if (rst)
            flags_q <= '0;
        else
            flags_q <= (flags_q & ~fi.clr) | eff;
    end

    assign fi.flags = flags_q;
    assign fi.hit   = |eff;
endmodule

// >>> swc_wake_ctrl.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns

// Contract
// - group-zero wake from stop resumes run, old clock, next instruction.
// - deep standby exits to run only on A bits 0 to 2 of group zero or group one.
// - group-zero wake from deep or cyclic stop fetches flash reset vector.
// - group-one A wake from deep standby: cyclic run, retention RAM vector.
// - group-one wake from cyclic stop: cyclic run, next instruction.
// - an effective wake event sets its flag bit to one.
// - each mask bit lines up with one source, flag and clear bit.
// - a source wakes only while its mask bit is zero.
// - writing one to a clear bit resets the matching flag.
// - flags record events only, not a standby exit.
// - cyclic stop exits to cyclic run on a group-zero or group-one event.
module swc_wake_ctrl
    import swc_pkg::*;
#(
    parameter int W = GRP_W
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    // wake sources
    input  wire logic [W-1:0]      src_g0_a,
    input  wire logic [W-1:0]      src_g0_i,
    input  wire logic [W-1:0]      src_g1_a,
    input  wire logic [W-1:0]      src_g1_i,
    // resume outputs
    output logic [1:0]             power_mode,
    output logic                   cyclic_run,
    output logic [1:0]             fetch_sel,
    output logic [1:0]             clk_sel,
    output logic                   wake_pulse,
    output logic                   irq
);

    // ====================================================================
    // flag banks
    // ====================================================================
    swc_flag_if #(.W(W)) g0a ();
    swc_flag_if #(.W(W)) g0i ();
    swc_flag_if #(.W(W)) g1a ();
    swc_flag_if #(.W(W)) g1i ();

    logic [W-1:0] mask_g0a_q;
    logic [W-1:0] mask_g0i_q;
    logic [W-1:0] mask_g1a_q;
    logic [W-1:0] mask_g1i_q;
    logic [W-1:0] deep_mask;
    swc_power_t   power_q;

    function automatic logic hit_at(input logic [ADDR_W-1:0] a,
                                    input logic [5:0] off,
                                    input logic strobe);
        return strobe && (a == off);
    endfunction

    function automatic logic [W-1:0] clr_val(input logic [ADDR_W-1:0] a,
                                             input logic [5:0] off);
        return hit_at(a, off, wr) ? wdata[W-1:0] : '0;
    endfunction

    // in deep standby only A bits 0 to 2 stay armed
    always_comb
    begin
        deep_mask = mask_g0a_q;
        if (power_q == SWC_DEEP)
            deep_mask[W-1:DEEP_SRC_N] = '1;
    end

    assign g0a.src  = src_g0_a;
    assign g0a.mask = deep_mask;
    assign g0a.clr  = clr_val(addr, OFF_CLR_G0A);
    assign g0i.src  = src_g0_i;
    assign g0i.mask = (power_q == SWC_DEEP) ? '1 : mask_g0i_q;
    assign g0i.clr  = clr_val(addr, OFF_CLR_G0I);
    assign g1a.src  = src_g1_a;
    assign g1a.mask = (power_q == SWC_DEEP) ? (mask_g1a_q | ~W'(7))
                                            : mask_g1a_q;
    assign g1a.clr  = clr_val(addr, OFF_CLR_G1A);
    assign g1i.src  = src_g1_i;
    assign g1i.mask = (power_q == SWC_DEEP) ? '1 : mask_g1i_q;
    assign g1i.clr  = clr_val(addr, OFF_CLR_G1I);

    swc_flag_bank #(.W(W)) u_g0a (.clk(clk), .rst(rst), .fi(g0a));
    swc_flag_bank #(.W(W)) u_g0i (.clk(clk), .rst(rst), .fi(g0i));
    swc_flag_bank #(.W(W)) u_g1a (.clk(clk), .rst(rst), .fi(g1a));
    swc_flag_bank #(.W(W)) u_g1i (.clk(clk), .rst(rst), .fi(g1i));

    // ====================================================================
    // mask registers
    // ====================================================================
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mask_g0a_q <= MASK_RST[W-1:0];
            mask_g0i_q <= MASK_RST[W-1:0];
            mask_g1a_q <= MASK_RST[W-1:0];
            mask_g1i_q <= MASK_RST[W-1:0];
        end
        else
        begin
            if (hit_at(addr, OFF_MASK_G0A, wr))
                mask_g0a_q <= wdata[W-1:0];
            if (hit_at(addr, OFF_MASK_G0I, wr))
                mask_g0i_q <= wdata[W-1:0];
            if (hit_at(addr, OFF_MASK_G1A, wr))
                mask_g1a_q <= wdata[W-1:0];
            if (hit_at(addr, OFF_MASK_G1I, wr))
                mask_g1i_q <= wdata[W-1:0];
        end
    end

    // ====================================================================
    // power mode sequencer
    // ====================================================================
    logic       cyc_q;
    logic       osc_lo_q;
    swc_cmd_t   cmd;
    logic       g0_hit;
    logic       g1_hit;
    logic       wake_q;

    assign cmd    = swc_cmd_t'(wdata[MODE_CMD_LSB +: 2]);
    assign g0_hit = g0a.hit | g0i.hit;
    assign g1_hit = g1a.hit | g1i.hit;

    always_ff @(posedge clk)
    begin
        if (rst)
            osc_lo_q <= 1'b0;
        else if (hit_at(addr, OFF_MODE, wr))
            osc_lo_q <= wdata[MODE_OSC_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            power_q   <= SWC_RUN;
            cyc_q     <= 1'b0;
            fetch_sel <= SWC_FETCH_NEXT;
            clk_sel   <= SWC_CLK_KEEP;
            wake_q    <= 1'b0;
        end
        else
        begin
            wake_q <= 1'b0;
            unique case (power_q)
                SWC_RUN:
                begin
                    if (hit_at(addr, OFF_MODE, wr))
                    begin
                        unique case (cmd)
                            SWC_CMD_STOP:     power_q <= SWC_STOP;
                            SWC_CMD_DEEP:     power_q <= SWC_DEEP;
                            SWC_CMD_CYC_STOP: power_q <= SWC_CYC_STOP;
                            SWC_CMD_NONE:     power_q <= SWC_RUN;
                        endcase
                    end
                end
                SWC_STOP:
                begin
                    if (g0_hit)
                    begin
                        power_q   <= SWC_RUN;
                        cyc_q     <= 1'b0;
                        clk_sel   <= SWC_CLK_KEEP;
                        fetch_sel <= SWC_FETCH_NEXT;
                        wake_q    <= 1'b1;
                    end
                end
                SWC_DEEP:
                begin
                    if (g0a.hit)
                    begin
                        power_q   <= SWC_RUN;
                        cyc_q     <= 1'b0;
                        clk_sel   <= osc_lo_q ? SWC_CLK_IOSC_LO
                                              : SWC_CLK_IOSC_HI;
                        fetch_sel <= SWC_FETCH_FLASH_RST;
                        wake_q    <= 1'b1;
                    end
                    else if (g1a.hit)
                    begin
                        power_q   <= SWC_RUN;
                        cyc_q     <= 1'b1;
                        clk_sel   <= osc_lo_q ? SWC_CLK_IOSC_LO
                                              : SWC_CLK_IOSC_HI;
                        fetch_sel <= SWC_FETCH_RRAM_RST;
                        wake_q    <= 1'b1;
                    end
                end
                SWC_CYC_STOP:
                begin
                    if (g0_hit || g1_hit)
                    begin
                        power_q   <= SWC_RUN;
                        cyc_q     <= 1'b1;
                        clk_sel   <= osc_lo_q ? SWC_CLK_IOSC_LO
                                              : SWC_CLK_IOSC_HI;
                        fetch_sel <= g0_hit ? SWC_FETCH_FLASH_RST
                                            : SWC_FETCH_NEXT;
                        wake_q    <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ====================================================================
    // interrupt: wake done, any flag set while running
    // ====================================================================
    logic [IRQ_N-1:0] irq_stat_q;
    logic [IRQ_N-1:0] irq_en_q;
    logic [IRQ_N-1:0] irq_evt;

    assign irq_evt[IRQ_WAKE] = wake_q;
    assign irq_evt[IRQ_FLAG] = (power_q == SWC_RUN) &&
                               (g0_hit || g1_hit);

    always_ff @(posedge clk)
    begin
        if (rst)
            irq_en_q <= '0;
        else if (hit_at(addr, OFF_IRQ_EN, wr))
            irq_en_q <= wdata[IRQ_N-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq_stat_q <= '0;
        else if (hit_at(addr, OFF_IRQ_CLR, wr))
            irq_stat_q <= (irq_stat_q & ~wdata[IRQ_N-1:0]) | irq_evt;
        else
            irq_stat_q <= irq_stat_q | irq_evt;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_q & irq_en_q);
    end

    // ====================================================================
    // outputs and read port
    // ====================================================================
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            power_mode <= SWC_RUN;
            cyclic_run <= 1'b0;
            wake_pulse <= 1'b0;
        end
        else
        begin
            power_mode <= power_q;
            cyclic_run <= cyc_q;
            wake_pulse <= wake_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= '0;
        else if (!rd)
            rdata <= '0;
        else
        begin
            rdata <= '0;
            unique case (addr)
                OFF_FLAG_G0A: rdata[W-1:0] <= g0a.flags;
                OFF_FLAG_G0I: rdata[W-1:0] <= g0i.flags;
                OFF_FLAG_G1A: rdata[W-1:0] <= g1a.flags;
                OFF_FLAG_G1I: rdata[W-1:0] <= g1i.flags;
                OFF_MASK_G0A: rdata[W-1:0] <= mask_g0a_q;
                OFF_MASK_G0I: rdata[W-1:0] <= mask_g0i_q;
                OFF_MASK_G1A: rdata[W-1:0] <= mask_g1a_q;
                OFF_MASK_G1I: rdata[W-1:0] <= mask_g1i_q;
                OFF_MODE:     rdata[MODE_OSC_BIT] <= osc_lo_q;
                OFF_STATUS:   rdata[4:0] <= {cyc_q, power_q, fetch_sel};
                OFF_IRQ_STAT: rdata[IRQ_N-1:0] <= irq_stat_q;
                OFF_IRQ_EN:   rdata[IRQ_N-1:0] <= irq_en_q;
                default:      rdata <= '0;
            endcase
        end
    end

endmodule

// >>> swc_wake_ctrl_monitor.sv
`timescale 1ns/1ns
module swc_wake_ctrl_monitor
    import swc_pkg::*;
#(
    parameter int W = GRP_W
)
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0]       wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [31:0]       rdata,
    // wake sources
    input wire logic [W-1:0]      src_g0_a,
    input wire logic [W-1:0]      src_g0_i,
    input wire logic [W-1:0]      src_g1_a,
    input wire logic [W-1:0]      src_g1_i,
    // resume outputs
    input wire logic [1:0]        power_mode,
    input wire logic              cyclic_run,
    input wire logic [1:0]        fetch_sel,
    input wire logic [1:0]        clk_sel,
    input wire logic              wake_pulse,
    input wire logic              irq
);
    // ====================================================================
    // mirrors of software-written registers
    // ====================================================================
    logic [W-1:0]     m0_q;
    logic [IRQ_N-1:0] ien_q;

    always_ff @(posedge clk)
    begin
        if (rst) m0_q <= MASK_RST[W-1:0];
        else if (wr && addr == OFF_MASK_G0A) m0_q <= wdata[W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst) ien_q <= '0;
        else if (wr && addr == OFF_IRQ_EN) ien_q <= wdata[IRQ_N-1:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ====================================================================
    // assertions
    // ====================================================================
    AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_CLR_READ: assert property (rd && addr >= OFF_CLR_G0A &&
        addr <= OFF_CLR_G1I |=> rdata == 32'h0)
        else $error("clear register read not zero");
    AST_UNMAPPED: assert property (rd && addr > OFF_IRQ_CLR |=> rdata == 0)
        else $error("unmapped read not zero");
    AST_MASK_READ: assert property (rd && addr == OFF_MASK_G0A |=>
        rdata[W-1:0] == $past(m0_q))
        else $error("mask readback wrong");
    AST_IEN_READ: assert property (rd && addr == OFF_IRQ_EN |=>
        rdata[IRQ_N-1:0] == $past(ien_q))
        else $error("irq enable readback wrong");
    AST_IRQ_GATE: assert property (irq |-> $past(ien_q) != '0)
        else $error("irq high with no enable");
    AST_STOP_EXIT: assert property ($past(power_mode) == SWC_STOP &&
        power_mode == SWC_RUN |-> fetch_sel == SWC_FETCH_NEXT &&
        clk_sel == SWC_CLK_KEEP && !cyclic_run)
        else $error("stop exit resume wrong");
    AST_DEEP_EXIT: assert property ($past(power_mode) == SWC_DEEP &&
        power_mode != SWC_DEEP |-> power_mode == SWC_RUN &&
        clk_sel != SWC_CLK_KEEP && fetch_sel == (cyclic_run ?
        SWC_FETCH_RRAM_RST : SWC_FETCH_FLASH_RST))
        else $error("deep standby exit resume wrong");
    AST_CYC_EXIT: assert property ($past(power_mode) == SWC_CYC_STOP &&
        power_mode != SWC_CYC_STOP |-> power_mode == SWC_RUN &&
        cyclic_run && fetch_sel != SWC_FETCH_RRAM_RST)
        else $error("cyclic stop exit resume wrong");
    AST_WAKE_PULSE: assert property ($past(power_mode) != SWC_RUN &&
        power_mode == SWC_RUN |-> wake_pulse ##1 !wake_pulse)
        else $error("wake pulse missing or long");

    COV_DEEP_G1: cover property (power_mode == SWC_DEEP ##1 cyclic_run);
    COV_CYC: cover property (power_mode == SWC_CYC_STOP ##1 wake_pulse);
    COV_IRQ: cover property (!irq ##1 irq);
endmodule

bind swc_wake_ctrl swc_wake_ctrl_monitor #(.W(W)) u_mon (.clk(clk),
    .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_g0_a(src_g0_a), .src_g0_i(src_g0_i),
    .src_g1_a(src_g1_a), .src_g1_i(src_g1_i), .power_mode(power_mode),
    .cyclic_run(cyclic_run), .fetch_sel(fetch_sel), .clk_sel(clk_sel),
    .wake_pulse(wake_pulse), .irq(irq));

// >>> tb_swc_wake_ctrl.sv
`timescale 1ns/1ns
module tb_swc_wake_ctrl
    import swc_pkg::*;
;
    logic              clk = 1'h0;
    logic              rst = 1'h1;
    logic              wr = 1'h0;
    logic              rd = 1'h0;
    logic [ADDR_W-1:0] addr = 6'h00;
    logic [31:0]       wdata = 32'h0;
    logic [31:0]       src [4] = '{default: 32'h0};
    logic [31:0]       flg [4] = '{default: 32'h0};
    logic [31:0]       msk [4] = '{default: MASK_RST};
    logic [31:0]       rdata;
    logic [1:0]        power_mode;
    logic [1:0]        fetch_sel;
    logic [1:0]        clk_sel;
    logic              cyclic_run;
    logic              wake_pulse;
    logic              irq;
    int                error_cnt = 0;
    int                tests_run = 0;

    always #50 clk = ~clk;

    swc_wake_ctrl dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .src_g0_a(src[0]),
        .src_g0_i(src[1]), .src_g1_a(src[2]), .src_g1_i(src[3]),
        .power_mode(power_mode), .cyclic_run(cyclic_run),
        .fetch_sel(fetch_sel), .clk_sel(clk_sel),
        .wake_pulse(wake_pulse), .irq(irq));

    // ====================================================================
    // tasks
    // ====================================================================
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task final_report();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // bus write, with the model of masks and clears kept beside it
    task wr32(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        if (a >= OFF_MASK_G0A && a <= OFF_MASK_G1I) msk[a - 6'h04] = d;
        if (a >= OFF_CLR_G0A && a <= OFF_CLR_G1I) flg[a - 6'h08] &= ~d;
    endtask

    task rdchk(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(rdata, e);
    endtask

    task pulse(input int g, input logic [31:0] v);
        @(posedge clk);
        src[g] <= v;
        @(posedge clk);
        src[g] <= 32'h0;
        flg[g] |= v & ~msk[g];
    endtask

    // enter a mode, offer an ineffective event when bad is nonzero, then a waking one
    task mode_case(input logic [31:0] cmd, input int g,
                   input logic [31:0] bad, input logic [31:0] v,
                   input logic [6:0] exp);
        wr32(OFF_MODE, cmd);
        repeat (2) @(posedge clk);
        if (bad != 0)
        begin
            pulse(g, bad);
            repeat (2) @(posedge clk);
        end
        #1;
        chk({30'h0, power_mode}, {30'h0, cmd[1:0]});
        pulse(g, v);
        @(posedge clk);
        #1;
        chk({25'h0, power_mode, cyclic_run, fetch_sel, clk_sel}, {25'h0, exp});
        chk({31'h0, wake_pulse}, 32'h1);
        @(posedge clk);
        #1;
        chk({31'h0, wake_pulse}, 32'h0);
        $display("test mode %0h done", cmd);
    endtask

    // ====================================================================
    // tests
    // ====================================================================
    initial
    begin
        #200000;
        error_cnt++;
        final_report();
    end

    initial
    begin
        void'($urandom(42));
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        for (int g = 0; g < 4; g++)
        begin
            rdchk(OFF_FLAG_G0A + 6'(g), 32'h0);
            rdchk(OFF_MASK_G0A + 6'(g), MASK_RST);
            rdchk(OFF_CLR_G0A + 6'(g), 32'h0);
        end
        wr32(6'h3f, $urandom());
        rdchk(6'h3f, 32'h0);
        $display("test reset done");
        for (int g = 0; g < 4; g++)
        begin
            pulse(g, $urandom());
            rdchk(OFF_FLAG_G0A + 6'(g), flg[g]);
            wr32(OFF_MASK_G0A + 6'(g), $urandom());
            pulse(g, $urandom());
            rdchk(OFF_FLAG_G0A + 6'(g), flg[g]);
            rdchk(OFF_MASK_G0A + 6'(g), msk[g]);
            wr32(OFF_CLR_G0A + 6'(g), $urandom());
            rdchk(OFF_FLAG_G0A + 6'(g), flg[g]);
            rdchk(OFF_CLR_G0A + 6'(g), 32'h0);
        end
        $display("test flags done");
        // each bit index is unmasked in one group only
        wr32(OFF_MASK_G0A, 32'hffffffdc);
        wr32(OFF_MASK_G0I, 32'hfffffff7);
        wr32(OFF_MASK_G1A, 32'hfffffffb);
        wr32(OFF_MASK_G1I, 32'hffffffef);
        mode_case(32'h1, 0, 32'h0, 32'h1, {SWC_RUN, 1'h0, SWC_FETCH_NEXT,
            SWC_CLK_KEEP});
        mode_case(32'h2, 0, 32'h20, 32'h2, {SWC_RUN, 1'h0,
            SWC_FETCH_FLASH_RST, SWC_CLK_IOSC_HI});
        mode_case(32'h12, 2, 32'h0, 32'h4, {SWC_RUN, 1'h1,
            SWC_FETCH_RRAM_RST, SWC_CLK_IOSC_LO});
        mode_case(32'h3, 3, 32'h0, 32'h10, {SWC_RUN, 1'h1, SWC_FETCH_NEXT,
            SWC_CLK_IOSC_HI});
        mode_case(32'h3, 1, 32'h0, 32'h8, {SWC_RUN, 1'h1,
            SWC_FETCH_FLASH_RST, SWC_CLK_IOSC_HI});
        rdchk(OFF_STATUS, {27'h0, 1'h1, SWC_RUN,
            SWC_FETCH_FLASH_RST});
        wr32(OFF_MODE, 32'h10);
        rdchk(OFF_MODE, 32'h10);
        chk({30'h0, power_mode}, {30'h0, SWC_RUN});
        rdchk(OFF_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr32(OFF_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        wr32(OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr32(OFF_IRQ_EN, 32'h1);
        wr32(OFF_IRQ_CLR, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        rdchk(OFF_IRQ_STAT, 32'h0);
        $display("test irq done");
        final_report();
    end
endmodule
